// ===== hdl/return_and_rotate_exec.sv
// Purpose: Executes literal return, interrupt return and byte rotates
// Assumes: Data memory answers a read on the cycle after o_mem.rd
// Notes: Accumulator, carry and interrupt enable live in this unit
`include "rr_exec_regs.svh"
module return_and_rotate_exec (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Instruction request
    input wire ret_rot_pkg::op_req_t i_req,
    output logic o_ready,
    output logic o_done,
    // Return stack and program counter
    input wire logic [`XU_PC_W-1:0] i_stack_top,
    output logic o_stack_pop,
    output logic [`XU_PC_W-1:0] o_pc,
    output logic o_pc_load,
    // Data memory
    output ret_rot_pkg::mem_cmd_t o_mem,
    input wire logic [`XU_DATA_W-1:0] i_mem_rdata,
    // Core state and interrupts
    input wire logic i_int_enable_clr,
    input wire logic i_int_pending,
    output logic o_int_service,
    output logic [`XU_DATA_W-1:0] o_acc,
    output logic o_carry,
    output logic o_int_enable
);
    ret_rot_pkg::core_t st_ff;
    ret_rot_pkg::core_t nxt_st;
    logic [`XU_DATA_W-1:0] rot_result;
    logic rot_carry;

    function automatic logic writes_mem(input ret_rot_pkg::opcode_t op);
        return (op == ret_rot_pkg::OP_ROTATE_LEFT_MEM) ||
               (op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_MEM) ||
               (op == ret_rot_pkg::OP_ROTATE_RIGHT_MEM);
    endfunction

    function automatic logic uses_carry(input ret_rot_pkg::opcode_t op);
        return (op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_MEM) ||
               (op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC);
    endfunction

    rotate_unit i_rotate_unit (
        .i_op(st_ff.op),
        .i_data(i_mem_rdata),
        .i_carry(st_ff.carry),
        .o_result(rot_result),
        .o_carry(rot_carry)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pc_load = 1'b0;
        nxt_st.stack_pop = 1'b0;
        nxt_st.int_service = 1'b0;
        nxt_st.done = 1'b0;
        nxt_st.mem.rd = 1'b0;
        nxt_st.mem.wr = 1'b0;
        // Interrupt entry elsewhere in the core clears the enable
        if (i_int_enable_clr) begin
            nxt_st.int_en = 1'b0;
        end
        unique case (st_ff.fsm)
            ret_rot_pkg::ST_IDLE: begin
                if (i_req.valid) begin
                    nxt_st.op = i_req.op;
                    nxt_st.mem.addr = i_req.addr;
                    unique case (i_req.op)
                        ret_rot_pkg::OP_RETURN_LOAD_LITERAL: begin
                            nxt_st.pc = i_stack_top;
                            nxt_st.pc_load = 1'b1;
                            nxt_st.stack_pop = 1'b1;
                            nxt_st.acc = i_req.imm;
                            nxt_st.done = 1'b1;
                        end
                        ret_rot_pkg::OP_INTERRUPT_RETURN: begin
                            nxt_st.pc = i_stack_top;
                            nxt_st.pc_load = 1'b1;
                            nxt_st.stack_pop = 1'b1;
                            // Setting the enable wins over a clear in the same cycle
                            nxt_st.int_en = 1'b1;
                            // A pending request diverts to its handler first
                            nxt_st.int_service = i_int_pending;
                            nxt_st.done = 1'b1;
                        end
                        ret_rot_pkg::OP_ROTATE_LEFT_MEM,
                        ret_rot_pkg::OP_ROTATE_LEFT_TO_ACC,
                        ret_rot_pkg::OP_ROTATE_LEFT_CARRY_MEM,
                        ret_rot_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC,
                        ret_rot_pkg::OP_ROTATE_RIGHT_MEM: begin
                            nxt_st.mem.rd = 1'b1;
                            nxt_st.fsm = ret_rot_pkg::ST_FETCH;
                        end
                        default: begin
                            // Unknown code completes with no effect
                            nxt_st.done = 1'b1;
                        end
                    endcase
                end
            end
            ret_rot_pkg::ST_FETCH: begin
                nxt_st.fsm = ret_rot_pkg::ST_EXEC;
            end
            ret_rot_pkg::ST_EXEC: begin
                if (writes_mem(st_ff.op)) begin
                    nxt_st.mem.wr = 1'b1;
                    nxt_st.mem.wdata = rot_result;
                end else begin
                    nxt_st.acc = rot_result;
                end
                if (uses_carry(st_ff.op)) begin
                    nxt_st.carry = rot_carry;
                end
                nxt_st.done = 1'b1;
                nxt_st.fsm = ret_rot_pkg::ST_IDLE;
            end
            default: begin
                nxt_st.fsm = ret_rot_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff.fsm <= ret_rot_pkg::ST_IDLE;
            st_ff.op <= ret_rot_pkg::OP_RETURN_LOAD_LITERAL;
            st_ff.mem <= '0;
            st_ff.acc <= `XU_RST_ACC;
            st_ff.carry <= `XU_RST_CARRY;
            st_ff.int_en <= `XU_RST_INT_EN;
            st_ff.pc <= `XU_RST_PC;
            st_ff.pc_load <= 1'b0;
            st_ff.stack_pop <= 1'b0;
            st_ff.int_service <= 1'b0;
            st_ff.done <= 1'b0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_ready = (st_ff.fsm == ret_rot_pkg::ST_IDLE);
    assign o_done = st_ff.done;
    assign o_stack_pop = st_ff.stack_pop;
    assign o_pc = st_ff.pc;
    assign o_pc_load = st_ff.pc_load;
    assign o_mem = st_ff.mem;
    assign o_int_service = st_ff.int_service;
    assign o_acc = st_ff.acc;
    assign o_carry = st_ff.carry;
    assign o_int_enable = st_ff.int_en;

    logic take;
    logic in_exec;
    assign take = i_ce && o_ready && i_req.valid;
    assign in_exec = i_ce && (st_ff.fsm == ret_rot_pkg::ST_EXEC);

    property p_return_load_literal;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && i_req.op == ret_rot_pkg::OP_RETURN_LOAD_LITERAL |=>
            o_pc_load && o_stack_pop && o_pc == $past(i_stack_top) &&
            o_acc == $past(i_req.imm) && o_carry == $past(o_carry) && !o_mem.wr;
    endproperty
    a_return_load_literal: assert property (p_return_load_literal)
        else $error("literal return wrong");

    property p_interrupt_return;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && i_req.op == ret_rot_pkg::OP_INTERRUPT_RETURN |=>
            o_int_enable && o_pc_load && o_pc == $past(i_stack_top) &&
            o_carry == $past(o_carry);
    endproperty
    a_interrupt_return: assert property (p_interrupt_return)
        else $error("interrupt return wrong");

    property p_interrupt_return_pend;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && i_req.op == ret_rot_pkg::OP_INTERRUPT_RETURN && i_int_pending |=>
            o_int_service && o_pc_load;
    endproperty
    a_interrupt_return_pend: assert property (p_interrupt_return_pend)
        else $error("pending interrupt skipped");

    property p_rot_fetch;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && (i_req.op inside {ret_rot_pkg::OP_ROTATE_LEFT_MEM,
                                  ret_rot_pkg::OP_ROTATE_LEFT_TO_ACC,
                                  ret_rot_pkg::OP_ROTATE_LEFT_CARRY_MEM,
                                  ret_rot_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC,
                                  ret_rot_pkg::OP_ROTATE_RIGHT_MEM}) |=>
            o_mem.rd && !o_ready && !o_done && o_mem.addr == $past(i_req.addr);
    endproperty
    a_rot_fetch: assert property (p_rot_fetch) else $error("operand read wrong");

    property p_rot_left_mem;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_exec && st_ff.op == ret_rot_pkg::OP_ROTATE_LEFT_MEM |=>
            o_mem.wr && o_mem.wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} &&
            o_carry == $past(o_carry) && o_acc == $past(o_acc);
    endproperty
    a_rot_left_mem: assert property (p_rot_left_mem) else $error("left rotate wrong");

    property p_rot_left_acc;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_exec && st_ff.op == ret_rot_pkg::OP_ROTATE_LEFT_TO_ACC |=>
            !o_mem.wr && o_acc == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} &&
            o_carry == $past(o_carry);
    endproperty
    a_rot_left_acc: assert property (p_rot_left_acc)
        else $error("left rotate to acc wrong");

    property p_rot_carry_mem;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_exec && st_ff.op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_MEM |=>
            o_mem.wr && o_mem.wdata == {$past(i_mem_rdata[6:0]), $past(o_carry)} &&
            o_carry == $past(i_mem_rdata[7]);
    endproperty
    a_rot_carry_mem: assert property (p_rot_carry_mem)
        else $error("carry left rotate wrong");

    property p_rot_carry_acc;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_exec && st_ff.op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC |=>
            !o_mem.wr && o_acc == {$past(i_mem_rdata[6:0]), $past(o_carry)} &&
            o_carry == $past(i_mem_rdata[7]);
    endproperty
    a_rot_carry_acc: assert property (p_rot_carry_acc)
        else $error("carry rotate to acc wrong");

    property p_rot_right_mem;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_exec && st_ff.op == ret_rot_pkg::OP_ROTATE_RIGHT_MEM |=>
            o_mem.wr && o_mem.wdata == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])} &&
            o_carry == $past(o_carry) && o_mem.addr == $past(o_mem.addr);
    endproperty
    a_rot_right_mem: assert property (p_rot_right_mem)
        else $error("right rotate wrong");
endmodule

// ===== hdl/rr_exec_regs.svh
// Purpose: Constants for the return and rotate execution unit
// Assumes: Included by the package and the top module
// Notes: Widths, bit positions and reset values below
`ifndef XU_EXEC_REGS_SVH
`define XU_EXEC_REGS_SVH
`define XU_PC_W 13
`define XU_MEM_AW 8
`define XU_DATA_W 8
`define XU_MSB_POS 7
`define XU_LSB_POS 0
`define XU_RST_ACC 8'h00
`define XU_RST_CARRY 1'h0
`define XU_RST_INT_EN 1'h0
`define XU_RST_PC 13'h0000
`endif

// ===== hdl/rr_exec_pkg.sv
// Purpose: Types for the return and rotate execution unit
// Assumes: Widths come from rr_exec_regs.svh
// Notes: Opcode codes are local to this unit
`include "rr_exec_regs.svh"
package ret_rot_pkg;
    typedef enum logic [2:0] {
        OP_RETURN_LOAD_LITERAL = 3'h0,
        OP_INTERRUPT_RETURN = 3'h1,
        OP_ROTATE_LEFT_MEM = 3'h2,
        OP_ROTATE_LEFT_TO_ACC = 3'h3,
        OP_ROTATE_LEFT_CARRY_MEM = 3'h4,
        OP_ROTATE_LEFT_CARRY_TO_ACC = 3'h5,
        OP_ROTATE_RIGHT_MEM = 3'h6
    } opcode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_FETCH = 3'h2,
        ST_EXEC = 3'h4
    } fsm_t;

    typedef struct packed {
        logic valid;
        opcode_t op;
        logic [`XU_DATA_W-1:0] imm;
        logic [`XU_MEM_AW-1:0] addr;
    } op_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [`XU_MEM_AW-1:0] addr;
        logic [`XU_DATA_W-1:0] wdata;
    } mem_cmd_t;

    typedef struct packed {
        fsm_t fsm;
        opcode_t op;
        mem_cmd_t mem;
        logic [`XU_DATA_W-1:0] acc;
        logic carry;
        logic int_en;
        logic [`XU_PC_W-1:0] pc;
        logic pc_load;
        logic stack_pop;
        logic int_service;
        logic done;
    } core_t;
endpackage

// ===== hdl/rotate_unit.sv
// Purpose: One-bit rotate of a data byte, plain or through carry
// Assumes: Purely combinational, driven by the execution unit
// Notes: Carry out is the old top bit for every operation, right rotate included
`include "rr_exec_regs.svh"
module rotate_unit (
    // Operation
    input wire ret_rot_pkg::opcode_t i_op,
    input wire logic [`XU_DATA_W-1:0] i_data,
    input wire logic i_carry,
    // Result
    output logic [`XU_DATA_W-1:0] o_result,
    output logic o_carry
);
    logic [`XU_DATA_W-1:0] left;
    logic [`XU_DATA_W-1:0] right;
    logic through_carry;

    assign through_carry = (i_op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_MEM) ||
                           (i_op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC);

    genvar g;
    generate
        for (g = 1; g < `XU_DATA_W; g++) begin : g_shift
            assign left[g] = i_data[g-1];
            assign right[g-1] = i_data[g];
        end
    endgenerate

    // Bit 0 takes either the old carry or the old top bit
    assign left[`XU_LSB_POS] = through_carry ? i_carry : i_data[`XU_MSB_POS];
    assign right[`XU_MSB_POS] = i_data[`XU_LSB_POS];

    always_comb begin
        o_result = (i_op == ret_rot_pkg::OP_ROTATE_RIGHT_MEM) ? right : left;
        o_carry = i_data[`XU_MSB_POS];
    end
endmodule

// ===== tb/test_return_and_rotate_exec.sv
// Purpose: Self-checking bench for the return and rotate execution unit
// Assumes: Memory answers one cycle after a read strobe, only on enabled edges
// Notes: Driver notes expected results, a monitor pops them on each done pulse
`include "rr_exec_regs.svh"
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_return_and_rotate_exec;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic ret;
        logic [`XU_PC_W-1:0] pc;
        logic isvc;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] acc;
        logic carry;
        logic int_en;
    } exp_t;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    ret_rot_pkg::op_req_t i_req = '0;
    logic [`XU_PC_W-1:0] i_stack_top = '0;
    logic [7:0] i_mem_rdata = 8'h00;
    logic i_int_enable_clr = 1'b0;
    logic i_int_pending = 1'b0;
    logic o_ready, o_done, o_stack_pop, o_pc_load, o_int_service, o_carry, o_int_enable;
    logic [`XU_PC_W-1:0] o_pc;
    logic [7:0] o_acc;
    ret_rot_pkg::mem_cmd_t o_mem;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    logic [7:0] exp_acc = `XU_RST_ACC;
    logic exp_carry = `XU_RST_CARRY;
    logic exp_int_en = `XU_RST_INT_EN;
    logic [`XU_PC_W-1:0] exp_pc = `XU_RST_PC;
    logic [31:0] seed = 32'h090d6f9e;
    logic [31:0] rs = 32'h090d6f9e;
    logic ce_rand = 1'b0;
    exp_t expq [$];
    exp_t m;
    int mismatches = 0;
    int samples_checked = 0;

    return_and_rotate_exec i_return_and_rotate_exec (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req),
        .o_ready(o_ready), .o_done(o_done), .i_stack_top(i_stack_top),
        .o_stack_pop(o_stack_pop), .o_pc(o_pc), .o_pc_load(o_pc_load),
        .o_mem(o_mem), .i_mem_rdata(i_mem_rdata), .i_int_enable_clr(i_int_enable_clr),
        .i_int_pending(i_int_pending), .o_int_service(o_int_service),
        .o_acc(o_acc), .o_carry(o_carry), .o_int_enable(o_int_enable));

    always #12.5 i_clk = ~i_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Clock enable jitter and the data memory; garbage on the read bus when not read
    always @(posedge i_clk) begin
        rs <= xs(rs);
        i_ce <= ce_rand ? (rs[2:0] != 3'h0) : 1'b1;
        if (i_ce && o_mem.wr) mem[o_mem.addr] <= o_mem.wdata;
        if (i_ce) i_mem_rdata <= o_mem.rd ? mem[o_mem.addr] : rs[15:8];
    end

    always @(posedge i_clk) begin
        if (i_rst_n && i_ce && o_done) begin
            if (expq.size() == 0) begin
                mismatches++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, o_done, 1'b0);
            end else begin
                m = expq.pop_front();
                `CHK({o_pc_load, o_stack_pop, o_pc}, {m.ret, m.ret, m.pc})
                `CHK(o_int_service, m.isvc)
                `CHK(o_mem.wr, m.wr)
                if (m.wr) `CHK({o_mem.addr, o_mem.wdata}, {m.addr, m.wdata})
                `CHK(o_acc, m.acc)
                `CHK({o_carry, o_int_enable}, {m.carry, m.int_en})
            end
        end
    end

    // Notes the expected outcome, then holds the request until it is taken
    task automatic issue(input logic [2:0] op);
        exp_t e;
        logic [7:0] d;
        logic [7:0] r;
        logic [31:0] v;
        seed = xs(seed);
        v = seed;
        e = '0;
        e.acc = exp_acc;
        e.carry = exp_carry;
        e.int_en = exp_int_en;
        e.pc = exp_pc;
        e.addr = {4'h0, v[3:0]};
        d = exp_mem[e.addr];
        r = (op == 3'h6) ? {d[0], d[7:1]} : {d[6:0], (op >= 3'h4) ? exp_carry : d[7]};
        case (op)
            3'h0: begin
                e.ret = 1'b1;
                e.acc = v[15:8];
            end
            3'h1: begin
                e.ret = 1'b1;
                e.int_en = 1'b1;
                e.isvc = v[31];
            end
            3'h2, 3'h4, 3'h6: begin
                e.wr = 1'b1;
                e.wdata = r;
                exp_mem[e.addr] = r;
            end
            3'h3, 3'h5: e.acc = r;
            default: ;
        endcase
        if (op == 3'h4 || op == 3'h5) e.carry = d[7];
        if (e.ret) e.pc = v[28:16];
        exp_acc = e.acc;
        exp_carry = e.carry;
        exp_int_en = e.int_en;
        exp_pc = e.pc;
        expq.push_back(e);
        i_req <= {1'b1, op, v[15:8], e.addr};
        i_stack_top <= v[28:16];
        i_int_pending <= v[31];
        do @(posedge i_clk); while (!(i_ce && o_ready));
    endtask

    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        finish_test();
    end

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 37);
            exp_mem[i] = 8'(i * 37);
        end
        repeat (4) @(posedge i_clk);
        `CHK({o_ready, o_done, o_acc, o_carry, o_int_enable, o_pc}, {1'h1, 1'h0, `XU_RST_ACC, `XU_RST_CARRY, `XU_RST_INT_EN, `XU_RST_PC})
        i_rst_n <= 1'b1;
        // Round 0 runs with the enable high; later rounds freeze random cycles
        for (int k = 0; k < 4; k++) begin
            ce_rand <= (k != 0);
            for (int n = 0; n < 100; n++) begin
                issue(3'(xs(seed + 32'(n)) >> 7));
            end
            i_req.valid <= 1'b0;
            for (int w = 0; w < 60 && expq.size() != 0; w++) @(posedge i_clk);
            `CHK(expq.size(), 0)
            i_int_enable_clr <= 1'b1;
            exp_int_en = 1'b0;
            repeat (8) @(posedge i_clk);
            i_int_enable_clr <= 1'b0;
            @(posedge i_clk);
            `CHK(o_int_enable, 1'b0)
        end
        finish_test();
    end
endmodule
